/* design/ocdg_top.sv */
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - option parts, byte 00H refuses session
// - byte 02H never erases on failures
// - byte 03H erases flash on failure
// - no-option parts, 00H erases on connect
// - no-option parts, illegal neighbour byte: erase, then session
// - no-option parts other than 02H, later failure schedules erase
// - no-option session keeps oscillator running
// - self-programmed 00H keeps link disabled
// - internal mode with download flag set runs internal oscillator
// - subclock mode runs target subclock
// - session only on matching security id
module ocdg_top #(
  parameter int ID_BYTES = ocdg_pkg::OCDG_ID_BYTES
) (
  // clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_sys_rst,
  // wishbone slave
  input  wire ocdg_pkg::ocdg_wb_req_t    i_wb,
  output logic [31:0]                    o_wb_dat,
  output logic                           o_wb_ack,
  // flash option contents
  input  wire logic                      i_has_opt,
  input  wire logic [7:0]                i_opt_byte,
  input  wire logic [7:0]                i_opt_rsvd,
  input  wire logic [ID_BYTES*8-1:0]     i_flash_id,
  // emulator link
  input  wire logic                      i_emu_attach,
  input  wire logic                      i_id_valid,
  input  wire logic [ID_BYTES*8-1:0]     i_id,
  output logic                           o_link_en,
  output logic                           o_session,
  // flash erase and self programming
  input  wire ocdg_pkg::ocdg_sp_wr_t     i_sp,
  input  wire logic                      i_ext_erase,
  input  wire logic                      i_erase_done,
  output logic                           o_erase_req,
  // clocking
  input  wire logic                      i_stop_req,
  output logic                           o_osc_stop,
  output logic [1:0]                     o_clk_sel
);
  import ocdg_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ocdg_state_t fsm;       // gate sequence
    ocdg_state_t after;     // state to take after an erase
    logic        att_m;     // attach sync stage one
    logic        att_s;     // attach sync stage two
    logic        has_opt;   // part has option bytes
    logic [7:0]  opt;       // sampled option byte
    logic [7:0]  rsvd;      // sampled neighbour byte
    logic        lock;      // link locked by self programming
    logic [2:0]  ctrl;      // clock mode and download flag
    logic [7:0]  fails;     // failed id attempts
    logic        ack;       // bus ack
    logic [31:0] rdat;      // bus read data
    logic        link_en;   // link enable out
    logic        session;   // session out
    logic        erase;     // erase request out
    logic        osc_stop;  // oscillator stop out
    logic [1:0]  clk_sel;   // clock select out
  } ocdg_regs_t;

  ocdg_regs_t q;            // registered state
  ocdg_regs_t d;            // next state

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  logic bus_req;            // new bus access
  logic id_match;           // host id equals stored id
  logic id_fail;            // failed id attempt
  logic fail_erase;         // failure must erase
  logic refuse;             // attach must be refused
  logic pre_erase;          // attach must erase first

  // option byte outside the allowed set
  function automatic logic opt_illegal(input logic [7:0] v);
    opt_illegal = (v != OCDG_OPT_LOCKED) && (v != OCDG_OPT_KEEP) &&
                  (v != OCDG_OPT_ERASE);
  endfunction : opt_illegal

  assign bus_req    = i_wb.cyc && i_wb.stb && !q.ack;
  assign id_match   = (i_id == i_flash_id);
  assign id_fail    = i_id_valid && !id_match;
  // 02H never erases; 03H always; other no-option settings do
  assign fail_erase = (q.opt != OCDG_OPT_KEEP) &&
                      ((q.opt == OCDG_OPT_ERASE) || !q.has_opt);
  assign refuse     = q.lock ||
                      (q.has_opt && ((q.opt == OCDG_OPT_LOCKED) ||
                                     opt_illegal(q.opt)));
  assign pre_erase  = !q.has_opt &&
                      ((q.opt == OCDG_OPT_LOCKED) ||
                       opt_illegal(q.opt) ||
                       (q.rsvd != OCDG_OPT_RSVD_OK));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    d       = q;
    d.erase = 1'b0;
    d.att_m = i_emu_attach;
    d.att_s = q.att_m;
    // gate sequence
    case (q.fsm)
      OCDG_ST_SAMPLE:
      begin
        // capture option contents once after reset
        d.has_opt = i_has_opt;
        d.opt     = i_opt_byte;
        d.rsvd    = i_opt_rsvd;
        d.fsm     = OCDG_ST_IDLE;
      end
      OCDG_ST_IDLE:
      begin
        // emulator attached: decide per sampled policy
        if (q.att_s && refuse)
        begin
          d.fsm = OCDG_ST_REFUSED;
        end
        else if (q.att_s && pre_erase)
        begin
          d.erase = 1'b1;
          d.after = OCDG_ST_AUTH;
          d.fsm   = OCDG_ST_ERASE;
        end
        else if (q.att_s)
        begin
          d.fsm = OCDG_ST_AUTH;
        end
      end
      OCDG_ST_AUTH:
      begin
        // wait for the host security id
        if (!q.att_s || q.lock)
        begin
          d.fsm = OCDG_ST_IDLE;
        end
        else if (i_id_valid && id_match)
        begin
          d.fsm = OCDG_ST_SESSION;
        end
        else if (id_fail && fail_erase)
        begin
          d.fails = q.fails + 8'h01;
          d.erase = 1'b1;
          d.after = OCDG_ST_IDLE;
          d.fsm   = OCDG_ST_ERASE;
        end
        else if (id_fail)
        begin
          d.fails = q.fails + 8'h01;
        end
      end
      OCDG_ST_SESSION:
      begin
        // session ends on detach or lock
        if (!q.att_s || q.lock)
        begin
          d.fsm = OCDG_ST_IDLE;
        end
      end
      OCDG_ST_REFUSED:
      begin
        // stays refused until the emulator leaves
        if (!q.att_s)
        begin
          d.fsm = OCDG_ST_IDLE;
        end
      end
      OCDG_ST_ERASE:
      begin
        // hold until the flash reports the erase done
        if (i_erase_done)
        begin
          d.fsm = q.after;
        end
      end
      default:
      begin
        d.fsm = OCDG_ST_SAMPLE;
      end
    endcase
    // self programming a locking value disables the link
    if (i_sp.wr && (i_sp.addr == OCDG_OPT_ADDR) &&
        (i_sp.data == OCDG_SP_LOCK_VAL))
    begin
      d.lock = 1'b1;
    end
    else if (i_ext_erase)
    begin
      d.lock = 1'b0;
    end
    // bus slave, one wait cycle
    d.ack  = bus_req;
    d.rdat = 32'h0;
    if (bus_req && !i_wb.we)
    begin
      if (i_wb.adr == OCDG_REG_CTRL)
      begin
        d.rdat = {29'h0, q.ctrl};
      end
      else if (i_wb.adr == OCDG_REG_STATUS)
      begin
        d.rdat = {q.fails, q.rsvd, q.opt, 2'h0, q.has_opt, q.lock,
                  1'b0, q.fsm};
      end
    end
    // a write lands on the edge that samples ack high
    else if (q.ack && i_wb.cyc && i_wb.stb && i_wb.we && i_wb.sel[0] &&
             (i_wb.adr == OCDG_REG_CTRL))
    begin
      d.ctrl = i_wb.dat[2:0];
    end
    // outputs, all from flops
    d.link_en  = ((q.fsm == OCDG_ST_AUTH) ||
                  (q.fsm == OCDG_ST_SESSION)) && !q.lock;
    d.session  = (q.fsm == OCDG_ST_SESSION);
    d.osc_stop = i_stop_req &&
                 !((q.fsm == OCDG_ST_SESSION) && !q.has_opt);
    d.clk_sel  = OCDG_CLK_HOST;
    if ((q.fsm == OCDG_ST_SESSION) &&
        (q.ctrl[OCDG_CTRL_MODE_LSB +: 2] == OCDG_CLK_SUB))
    begin
      d.clk_sel = OCDG_CLK_SUB;
    end
    else if ((q.fsm == OCDG_ST_SESSION) && q.ctrl[OCDG_CTRL_DL_BIT] &&
             (q.ctrl[OCDG_CTRL_MODE_LSB +: 2] == OCDG_CLK_INT))
    begin
      d.clk_sel = OCDG_CLK_INT;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      q         <= '0;
      q.fsm     <= OCDG_ST_SAMPLE;
      q.after   <= OCDG_ST_IDLE;
      q.ctrl    <= OCDG_CTRL_RST;
      q.clk_sel <= OCDG_CLK_HOST;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_wb_dat    = q.rdat;
  assign o_wb_ack    = q.ack;
  assign o_link_en   = q.link_en;
  assign o_session   = q.session;
  assign o_erase_req = q.erase;
  assign o_osc_stop  = q.osc_stop;
  assign o_clk_sel   = q.clk_sel;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_REFUSE_LOCKED: assert property (
    q.fsm == OCDG_ST_IDLE && q.att_s && q.has_opt &&
    q.opt == OCDG_OPT_LOCKED |=> q.fsm == OCDG_ST_REFUSED ##1 !o_link_en)
    else $error("locked option byte did not refuse");
  AST_KEEP_NO_ERASE: assert property (
    q.fsm != OCDG_ST_SAMPLE && q.opt == OCDG_OPT_KEEP &&
    q.fsm != OCDG_ST_IDLE |-> !d.erase)
    else $error("erase issued under keep setting");
  AST_FAIL_ERASE: assert property (
    q.fsm == OCDG_ST_AUTH && q.att_s && !q.lock && id_fail &&
    q.opt == OCDG_OPT_ERASE |=> o_erase_req && q.fsm == OCDG_ST_ERASE)
    else $error("failed id did not erase");
  AST_CONNECT_ERASE: assert property (
    q.fsm == OCDG_ST_IDLE && q.att_s && !q.lock && !q.has_opt &&
    q.opt == OCDG_OPT_LOCKED |=> o_erase_req ##1 !o_erase_req)
    else $error("connect did not erase");
  AST_RSVD_ERASE: assert property (
    q.fsm == OCDG_ST_IDLE && q.att_s && !q.lock && !q.has_opt &&
    q.rsvd != OCDG_OPT_RSVD_OK |=> q.after == OCDG_ST_AUTH && o_erase_req)
    else $error("illegal neighbour byte did not erase first");
  AST_NOOPT_FAIL: assert property (
    q.fsm == OCDG_ST_AUTH && q.att_s && !q.lock && id_fail &&
    !q.has_opt && q.opt != OCDG_OPT_KEEP |=> o_erase_req)
    else $error("no-option failure did not erase");
  AST_OSC_RUN: assert property (
    q.fsm == OCDG_ST_SESSION && !q.has_opt |=> !o_osc_stop)
    else $error("oscillator stopped in session");
  AST_LOCK: assert property (
    i_sp.wr && i_sp.addr == OCDG_OPT_ADDR &&
    i_sp.data == OCDG_SP_LOCK_VAL && !i_ext_erase
    |=> q.lock ##1 !o_link_en)
    else $error("locking write left link enabled");
  AST_INT_CLK: assert property (
    q.fsm == OCDG_ST_SESSION && q.ctrl == 3'h5 |=> o_clk_sel == OCDG_CLK_INT)
    else $error("internal oscillator not selected");
  AST_SUB_CLK: assert property (
    q.fsm == OCDG_ST_SESSION && q.ctrl[1:0] == OCDG_CLK_SUB
    |=> o_clk_sel == OCDG_CLK_SUB)
    else $error("subclock not selected");
  AST_ID_MATCH: assert property (
    q.fsm == OCDG_ST_AUTH ##1 q.fsm == OCDG_ST_SESSION
    |-> $past(i_id_valid) && $past(id_match))
    else $error("session without matching id");
  AST_HOLD_OPT: assert property (
    q.fsm != OCDG_ST_SAMPLE |=> $stable(q.opt) && $stable(q.has_opt))
    else $error("option policy changed");
  AST_BUS_ACK: assert property (
    bus_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not one cycle");

  COV_SESSION: cover property (q.fsm == OCDG_ST_AUTH ##1
                               q.fsm == OCDG_ST_SESSION);
  COV_REFUSE:  cover property (q.fsm == OCDG_ST_REFUSED);
  COV_PRE_ER:  cover property (q.after == OCDG_ST_AUTH && o_erase_req);
  COV_LOCK:    cover property (q.lock && q.fsm == OCDG_ST_IDLE);

endmodule : ocdg_top

/* design/ocdg_pkg.sv */
// ****************************************************************
// shared constants and types of the debug access gate
// ****************************************************************
package ocdg_pkg;

  // ****************************************************************
  // option byte values
  // ****************************************************************
  localparam logic [7:0] OCDG_OPT_LOCKED    = 8'h00; // refuse or erase
  localparam logic [7:0] OCDG_OPT_KEEP      = 8'h02; // never erase on failure
  localparam logic [7:0] OCDG_OPT_ERASE     = 8'h03; // erase on failure
  localparam logic [7:0] OCDG_OPT_RSVD_OK   = 8'h00; // neighbour legal
  localparam logic [7:0] OCDG_OPT_ADDR      = 8'h84; // debug option byte
  localparam logic [7:0] OCDG_SP_LOCK_VAL   = 8'h00; // locking write value
  localparam int         OCDG_ID_BYTES      = 10;    // security id length

  // ****************************************************************
  // register map, byte addresses on the bus
  // ****************************************************************
  localparam logic [3:0] OCDG_REG_CTRL      = 4'h0;  // clock mode control
  localparam logic [3:0] OCDG_REG_STATUS    = 4'h4;  // gate state
  localparam int         OCDG_CTRL_MODE_LSB = 0;     // clock mode field
  localparam int         OCDG_CTRL_DL_BIT   = 2;     // download finished
  localparam logic [2:0] OCDG_CTRL_RST      = 3'h0;  // ctrl reset value

  // ****************************************************************
  // clock selections
  // ****************************************************************
  localparam logic [1:0] OCDG_CLK_HOST      = 2'h0;  // host chosen clock
  localparam logic [1:0] OCDG_CLK_INT       = 2'h1;  // internal oscillator
  localparam logic [1:0] OCDG_CLK_SUB       = 2'h2;  // target subclock

  // gate sequence states
  typedef enum logic [2:0] {
    OCDG_ST_SAMPLE,
    OCDG_ST_IDLE,
    OCDG_ST_AUTH,
    OCDG_ST_SESSION,
    OCDG_ST_REFUSED,
    OCDG_ST_ERASE
  } ocdg_state_t;

  // wishbone request bundle
  typedef struct packed {
    logic        cyc;   // bus cycle
    logic        stb;   // strobe
    logic        we;    // write enable
    logic [3:0]  adr;   // byte address
    logic [3:0]  sel;   // byte lanes
    logic [31:0] dat;   // write data
  } ocdg_wb_req_t;

  // self programming write bundle
  typedef struct packed {
    logic        wr;    // write pulse
    logic [7:0]  addr;  // flash byte address
    logic [7:0]  data;  // written byte
  } ocdg_sp_wr_t;

endpackage : ocdg_pkg

/* bench/ocdg_emu_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// emulator side of the debug link
// ****************************************************************
module ocdg_emu_model #(
  parameter int ID_BYTES = 10
) (
  // clock
  input  wire logic                  i_mclk,
  // link pins toward the gate
  output logic                       o_attach,
  output logic                       o_id_valid,
  output logic [ID_BYTES*8-1:0]      o_id
);
  // no ram monitor traffic: the reserved ram range stays untouched
  // probe starts unplugged, id bus idle
  initial
  begin
    o_attach   = 1'b0;
    o_id_valid = 1'b0;
    o_id       = '0;
  end
  // plug or unplug the probe, changed after an edge
  task automatic plug(input logic v);
    @(posedge i_mclk);
    o_attach <= v;
  endtask : plug
  // one id attempt as a single cycle pulse
  task automatic try_id(input logic [ID_BYTES*8-1:0] id);
    @(posedge i_mclk);
    o_id_valid <= 1'b1;
    o_id       <= id;
    @(posedge i_mclk);
    o_id_valid <= 1'b0;
    o_id       <= ~id; // stale id scrambled
  endtask : try_id
endmodule : ocdg_emu_model

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ocdg_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic         mclk = 0, sys_rst = 1, has_opt = 0, stop_req = 0;
  logic         ext_erase = 0, erase_done = 0;
  logic [7:0]   opt_byte = 0, opt_rsvd = 0;
  logic [79:0]  flash_id = 0;
  ocdg_wb_req_t wb = '0;
  ocdg_sp_wr_t  sp = '0;
  logic [31:0]  wb_dat, rng = 32'h9b950632;
  logic         wb_ack, link_en, session, erase_req, osc_stop;
  logic         attach, id_valid;
  logic [79:0]  id;
  logic [1:0]   clk_sel;
  logic [31:0]  exp_q[$]; // expected read data
  int           num_errors = 0, check_count = 0, erase_cnt = 0, exp_er = 0;
  logic [31:0]  e;
  always #2.5 mclk = ~mclk;
  ocdg_top ocdg_top_inst (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_wb(wb),
    .o_wb_dat(wb_dat), .o_wb_ack(wb_ack), .i_has_opt(has_opt),
    .i_opt_byte(opt_byte), .i_opt_rsvd(opt_rsvd), .i_flash_id(flash_id),
    .i_emu_attach(attach), .i_id_valid(id_valid), .i_id(id),
    .o_link_en(link_en), .o_session(session), .i_sp(sp),
    .i_ext_erase(ext_erase), .i_erase_done(erase_done),
    .o_erase_req(erase_req), .i_stop_req(stop_req), .o_osc_stop(osc_stop),
    .o_clk_sel(clk_sel));
  ocdg_emu_model ocdg_emu_model_inst (.i_mclk(mclk), .o_attach(attach),
    .o_id_valid(id_valid), .o_id(id));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // an id that surely differs from the stored one
  function automatic logic [79:0] bad_id();
    return flash_id ^ 80'({xs(), xs(), xs() | 32'h1});
  endfunction : bad_id
  // expected status word from the captured option values
  function automatic logic [31:0] st(logic [2:0] s, logic [7:0] c);
    return {c, opt_rsvd, opt_byte, 2'b00, has_opt, 1'b0, 1'b0, s};
  endfunction : st
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // classic wishbone cycle, held until ack is sampled
  task automatic wb_io(input logic we, input logic [3:0] a,
                       input logic [31:0] d, exp);
    int i;
    @(posedge mclk);
    wb <= '{1'b1, 1'b1, we, a, 4'(xs()) | 4'h1, d};
    if (!we)
      exp_q.push_back(exp);
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (wb_ack === 1'b1)
        break;
    end
    wb <= '0;
    if (i == 20)
    begin
      num_errors++;
      wrap_up();
    end
  endtask : wb_io
  // bounded wait: 0 link enable, 1 session, 2 erase request
  task automatic wait_on(input int k, input logic v);
    int i;
    logic s;
    for (i = 0; i < 60; i++)
    begin
      @(negedge mclk);
      s = (k == 0) ? link_en : (k == 1) ? session : erase_req;
      if (s === v)
        break;
    end
    if (i == 60)
    begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_on
  // one cycle pulse: 0 erase finished, 1 external erase
  task automatic pulse(input int k);
    @(posedge mclk);
    if (k == 0) erase_done <= 1'b1; else ext_erase <= 1'b1;
    @(posedge mclk);
    if (k == 0) erase_done <= 1'b0; else ext_erase <= 1'b0;
  endtask : pulse
  task automatic sp_wr(input logic [7:0] a, d);
    @(posedge mclk);
    sp <= '{1'b1, a, d};
    @(posedge mclk);
    sp <= '0;
  endtask : sp_wr
  // reset with a new flash image
  task automatic restart(input logic h, input logic [7:0] o, r);
    @(posedge mclk);
    sys_rst  <= 1'b1;
    has_opt  <= h;
    opt_byte <= o;
    opt_rsvd <= r;
    tick(12);
    sys_rst  <= 1'b0;
  endtask : restart
  // ****************************************************************
  // watchers: read data against oldest note, erase pulse count
  // ****************************************************************
  always @(posedge mclk)
    if (wb_ack === 1'b1 && !wb.we)
      check("rdata", wb_dat, exp_q.pop_front());
  always @(posedge mclk)
    if (erase_req === 1'b1)
      erase_cnt++;
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    flash_id = 80'({xs(), xs(), xs()});
    // option part, 00H: refused
    restart(1'b1, OCDG_OPT_LOCKED, OCDG_OPT_RSVD_OK);
    ocdg_emu_model_inst.plug(1'b1);
    tick(6); // sync plus state step
    check("link", link_en, 0);
    wb_io(1'b0, OCDG_REG_STATUS, 0, st(3'h4, 8'h00));
    wb_io(1'b0, 4'h8, 0, 0);
    ocdg_emu_model_inst.plug(1'b0);
    // option part, 02H: failures never erase
    restart(1'b1, OCDG_OPT_KEEP, OCDG_OPT_RSVD_OK);
    ocdg_emu_model_inst.plug(1'b1);
    wait_on(0, 1'b1);
    repeat (3) ocdg_emu_model_inst.try_id(bad_id());
    tick(3);
    check("erases", erase_cnt, exp_er);
    e = st(3'h2, 8'h03);
    @(posedge mclk) opt_byte <= OCDG_OPT_LOCKED;
    wb_io(1'b0, OCDG_REG_STATUS, 0, e);
    @(posedge mclk) opt_byte <= OCDG_OPT_KEEP;
    ocdg_emu_model_inst.try_id(flash_id);
    wait_on(1, 1'b1);
    @(posedge mclk) stop_req <= 1'b1;
    tick(3);
    check("osc_stop", osc_stop, 1);
    for (int k = 5; k >= 0; k--)
    begin
      wb_io(1'b1, OCDG_REG_CTRL, 32'(k), 0);
      tick(2);
      e = (k % 4 == 2) ? 2 : (k == 5) ? 1 : 0;
      check("clk_sel", clk_sel, e);
    end
    wb_io(1'b1, OCDG_REG_STATUS, 32'hffffffff, 0);
    wb_io(1'b0, OCDG_REG_STATUS, 0, st(3'h3, 8'h03));
    sp_wr(8'h83, 8'(xs()));
    tick(3);
    check("link", link_en, 1);
    sp_wr(OCDG_OPT_ADDR, OCDG_SP_LOCK_VAL);
    wait_on(0, 1'b0);
    tick(2);
    check("session", session, 0);
    ocdg_emu_model_inst.plug(1'b0);
    tick(4);
    ocdg_emu_model_inst.plug(1'b1);
    tick(6);
    check("link", link_en, 0);
    ocdg_emu_model_inst.plug(1'b0);
    pulse(1);
    ocdg_emu_model_inst.plug(1'b1);
    wait_on(0, 1'b1);
    ocdg_emu_model_inst.plug(1'b0);
    // option part, 03H: failure erases
    restart(1'b1, OCDG_OPT_ERASE, OCDG_OPT_RSVD_OK);
    ocdg_emu_model_inst.plug(1'b1);
    wait_on(0, 1'b1);
    ocdg_emu_model_inst.try_id(bad_id());
    wait_on(2, 1'b1);
    exp_er++;
    @(negedge mclk);
    check("link", link_en, 0);
    pulse(0);
    wait_on(0, 1'b1);
    ocdg_emu_model_inst.plug(1'b0);
    // no option byte, 00H: erase on connect
    restart(1'b0, OCDG_OPT_LOCKED, OCDG_OPT_RSVD_OK);
    ocdg_emu_model_inst.plug(1'b1);
    wait_on(2, 1'b1);
    exp_er++;
    pulse(0);
    wait_on(0, 1'b1);
    check("osc_stop", osc_stop, 1);
    ocdg_emu_model_inst.try_id(flash_id);
    wait_on(1, 1'b1);
    tick(2);
    check("osc_stop", osc_stop, 0);
    ocdg_emu_model_inst.plug(1'b0);
    // no option byte, illegal 1EH: erase, then later failure erases
    restart(1'b0, 8'h1e, OCDG_OPT_RSVD_OK);
    ocdg_emu_model_inst.plug(1'b1);
    wait_on(2, 1'b1);
    pulse(0);
    wait_on(0, 1'b1);
    ocdg_emu_model_inst.try_id(bad_id());
    wait_on(2, 1'b1);
    exp_er += 2;
    ocdg_emu_model_inst.plug(1'b0);
    pulse(0);
    // no option byte, 02H with illegal neighbour
    restart(1'b0, OCDG_OPT_KEEP, 8'h5a);
    ocdg_emu_model_inst.plug(1'b1);
    wait_on(2, 1'b1);
    exp_er++;
    pulse(0);
    wait_on(0, 1'b1);
    ocdg_emu_model_inst.try_id(bad_id());
    tick(3);
    check("erases", erase_cnt, exp_er);
    wb_io(1'b0, OCDG_REG_STATUS, 0, st(3'h2, 8'h01));
    tick(2);
    wrap_up();
  end
endmodule : testbench
